// ---- hdl/ser_pkg.sv ----
package ser_pkg;

    // ****************************************************************
    // Command codes presented by the upstream command parser.
    // ****************************************************************
    localparam logic [2:0] CMD_NONE = 3'h0;   // No command.
    localparam logic [2:0] CMD_ENABLE_SET = 3'h1;   // Load whole mask.
    localparam logic [2:0] CMD_ENABLE_BIT_SET = 3'h2;   // Write one mask bit.
    localparam logic [2:0] CMD_ENABLE_QUERY = 3'h3;   // Read whole mask.
    localparam logic [2:0] CMD_ENABLE_BIT_QUERY = 3'h4;   // Read one mask bit.
    localparam logic [2:0] CMD_ERROR_QUERY = 3'h5;   // Read and clear word.
    localparam logic [2:0] CMD_ERROR_BIT_QUERY = 3'h6;   // Read, clear one bit.
    localparam logic [2:0] CMD_STATUS_QUERY = 3'h7;   // Read, clear status.

    // ****************************************************************
    // Field positions and widths.
    // ****************************************************************
    localparam int EVENT_WIDTH = 8;            // Event status and mask width.
    localparam int ERROR_WIDTH = 16;           // Error status word width.
    localparam int EVT_OPC = 0;                // Operation complete.
    localparam int EVT_EXE = 4;                // Execution error.
    localparam int EVT_CME = 5;                // Command syntax error.
    localparam int EVT_PON = 7;                // Power-on.
    localparam int ERR_SELFTEST = 0;           // Selftest failure.
    localparam int ERR_FIRST_PIRANI = 11;      // First Pirani gauge fault.
    localparam int SPOLL_SUMMARY = 5;          // Summary bit in serial poll.

    // Only bits 0, 4, 5 and 7 of the event status are implemented.
    localparam logic [7:0] EVENT_USED = 8'hb1;
    // Only bits 0 to 11 of the error word have sources.
    localparam logic [15:0] ERROR_USED = 16'h0fff;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] EVENT_RESET = 8'h00;
    localparam logic [15:0] ERROR_RESET = 16'h0000;

    // A command as handed over by the parser.
    typedef struct packed {
        logic valid;       // One-cycle strobe.
        logic [2:0] code;  // Command code.
        logic [7:0] arg_a; // Value or bit index.
        logic arg_b;       // Bit value for single-bit set.
    } ser_cmd_t;

    // A query answer.
    typedef struct packed {
        logic valid;        // One-cycle strobe.
        logic [15:0] value; // Decimal value as binary.
    } ser_reply_t;

endpackage

// ---- hdl/ser_status_event.sv ----
`timescale 1ns/10ps
`default_nettype none

module ser_status_event
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ser_pkg::ser_cmd_t cmd,
    input wire logic clear_status,
    input wire logic power_on_clear,
    input wire logic power_up,
    input wire logic [ser_pkg::EVENT_WIDTH-1:0] event_set,
    input wire logic [ser_pkg::ERROR_WIDTH-1:0] error_set,
    input wire logic spoll_summary_enable,
    output ser_pkg::ser_reply_t reply,
    output logic [ser_pkg::EVENT_WIDTH-1:0] enable_mask,
    output logic [ser_pkg::EVENT_WIDTH-1:0] event_status,
    output logic [ser_pkg::ERROR_WIDTH-1:0] error_status,
    output logic event_summary,
    output logic service_request
);

    // ****************************************************************
    // Command decode.
    // ****************************************************************

    // Each strobe is high for the one cycle in which a command arrives.
    logic do_set;
    logic do_bit_set;
    logic do_err_all;
    logic do_err_bit;
    logic do_evt_read;
    // Bit masks selected by the index argument, zero when out of range.
    logic [ser_pkg::EVENT_WIDTH-1:0] evt_index_mask;
    logic [ser_pkg::ERROR_WIDTH-1:0] err_index_mask;
    // Masks of bits cleared this cycle, by a read or, for events, also a status clear.
    logic [ser_pkg::ERROR_WIDTH-1:0] err_clear;
    logic [ser_pkg::EVENT_WIDTH-1:0] evt_clear;
    // Next value of the enable mask, read by the summary logic.
    logic [ser_pkg::EVENT_WIDTH-1:0] next_enable_mask;
    // Next values of the two status registers.
    logic [ser_pkg::ERROR_WIDTH-1:0] next_error_status;
    logic [ser_pkg::EVENT_WIDTH-1:0] next_event_status;

    assign do_set = cmd.valid && (cmd.code == ser_pkg::CMD_ENABLE_SET);
    assign do_bit_set = cmd.valid && (cmd.code == ser_pkg::CMD_ENABLE_BIT_SET);
    assign do_err_all = cmd.valid && (cmd.code == ser_pkg::CMD_ERROR_QUERY);
    assign do_err_bit = cmd.valid &&
        (cmd.code == ser_pkg::CMD_ERROR_BIT_QUERY);
    assign do_evt_read = cmd.valid && (cmd.code == ser_pkg::CMD_STATUS_QUERY);

    // Decode the index into a one-hot mask; large indices select nothing.
    always_comb
    begin
        evt_index_mask = '0;
        err_index_mask = '0;
        if (cmd.arg_a < 8'(ser_pkg::EVENT_WIDTH))
        begin
            evt_index_mask[cmd.arg_a[2:0]] = 1'b1;
        end
        if (cmd.arg_a < 8'(ser_pkg::ERROR_WIDTH))
        begin
            err_index_mask[cmd.arg_a[3:0]] = 1'b1;
        end
    end

    // ****************************************************************
    // Enable mask.
    // ****************************************************************

    // The mask holds its value until a set command rewrites it.
    always_comb
    begin
        next_enable_mask = enable_mask;
        if (do_set)
        begin
            next_enable_mask = cmd.arg_a;
        end
        else if (do_bit_set)
        begin
            // Only the indexed bit changes; others keep their value.
            next_enable_mask = (enable_mask & ~evt_index_mask) |
                ({ser_pkg::EVENT_WIDTH{cmd.arg_b}} & evt_index_mask);
        end
    end

    // The mask register. The summary reads the next value, so that it
    // never lags a mask write by one cycle.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            enable_mask <= ser_pkg::ENABLE_RESET;
        end
        else
        begin
            enable_mask <= next_enable_mask;
        end
    end

    // ****************************************************************
    // Standard event status.
    // ****************************************************************

    // A read or clear-status empties the register; a new event in the
    // same cycle still lands, so the set wins over the clear.
    always_comb
    begin
        evt_clear = '0;
        if (do_evt_read || clear_status ||
            (power_up && power_on_clear))
        begin
            evt_clear = '1;
        end
        next_event_status = ((event_status & ~evt_clear) | event_set) &
            ser_pkg::EVENT_USED;
    end

    // The event status register is sticky until cleared.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            event_status <= ser_pkg::EVENT_RESET;
        end
        else
        begin
            event_status <= next_event_status;
        end
    end

    // ****************************************************************
    // Error status word.
    // ****************************************************************

    // The whole-word query clears every bit, an indexed query only one.
    always_comb
    begin
        err_clear = '0;
        if (do_err_all)
        begin
            err_clear = '1;
        end
        else if (do_err_bit)
        begin
            err_clear = err_index_mask;
        end
        // Bit 0 is selftest, 1 to 11 the listed faults; set wins.
        next_error_status = ((error_status & ~err_clear) | error_set) &
            ser_pkg::ERROR_USED;
    end

    // The error word is sticky until read.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            error_status <= ser_pkg::ERROR_RESET;
        end
        else
        begin
            error_status <= next_error_status;
        end
    end

    // ****************************************************************
    // Summary and service request.
    // ****************************************************************

    // Recomputed every cycle from the next status and mask values.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            event_summary <= 1'b0;
            service_request <= 1'b0;
        end
        else
        begin
            event_summary <= |(next_event_status & next_enable_mask);
            service_request <= (|(next_event_status & next_enable_mask)) &&
                spoll_summary_enable;
        end
    end

    // ****************************************************************
    // Query answers.
    // ****************************************************************

    // Answers show the value before any clear from the same query.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            reply <= '0;
        end
        else
        begin
            reply.valid <= 1'b0;
            reply.value <= '0;
            if (cmd.valid)
            begin
                unique case (cmd.code)
                    ser_pkg::CMD_ENABLE_QUERY:
                    begin
                        reply.valid <= 1'b1;
                        reply.value <= {8'h00, enable_mask};
                    end
                    ser_pkg::CMD_ENABLE_BIT_QUERY:
                    begin
                        reply.valid <= 1'b1;
                        reply.value <= {15'h0000,
                            |(enable_mask & evt_index_mask)};
                    end
                    ser_pkg::CMD_ERROR_QUERY:
                    begin
                        reply.valid <= 1'b1;
                        reply.value <= error_status;
                    end
                    ser_pkg::CMD_ERROR_BIT_QUERY:
                    begin
                        reply.valid <= 1'b1;
                        reply.value <= {15'h0000,
                            |(error_status & err_index_mask)};
                    end
                    ser_pkg::CMD_STATUS_QUERY:
                    begin
                        reply.valid <= 1'b1;
                        reply.value <= {8'h00, event_status};
                    end
                    default:
                    begin
                        reply.valid <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ---- tb/ser_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host side: issues one parser command at a time.
module ser_host
(
    input wire logic sys_clk,
    output var ser_pkg::ser_cmd_t cmd
);
    initial cmd = '0;
    // Strobe rises at a falling edge and drops at the next one, so the
    // rising edge between them takes it exactly once.
    // Released arguments are inverted so stale values are never reused.
    task automatic send(input logic [2:0] c, input logic [7:0] a,
        input logic b);
        @(negedge sys_clk);
        cmd = {1'b1, c, a, b};
        @(negedge sys_clk);
        cmd = {1'b0, c, ~a, ~b};
    endtask
endmodule
`default_nettype wire

// ---- tb/ser_status_event_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module ser_status_event_props
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ser_pkg::ser_cmd_t cmd,
    input wire logic [15:0] error_set,
    input wire logic spoll_summary_enable,
    input wire ser_pkg::ser_reply_t reply,
    input wire logic [7:0] enable_mask,
    input wire logic [7:0] event_status,
    input wire logic [15:0] error_status,
    input wire logic event_summary,
    input wire logic service_request
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // Query commands are codes above the two set commands.
    wire logic is_query = cmd.valid && cmd.code > 3'h2;
    wire logic is_set = cmd.valid && cmd.code inside {3'h1, 3'h2};
    // Selected error bit, as the indexed query should answer it.
    wire logic [15:0] err_sel = (error_status >> cmd.arg_a[3:0]) & 16'h0001;
    reply_timing_a: assert property (reply.valid == $past(is_query))
        else $error("reply strobe out of step with query");
    mask_load_a: assert property (cmd.valid &&
        cmd.code == ser_pkg::CMD_ENABLE_SET |=> enable_mask == $past(cmd.arg_a))
        else $error("mask not loaded");
    mask_bit_a: assert property (cmd.valid &&
        cmd.code == ser_pkg::CMD_ENABLE_BIT_SET && cmd.arg_a < 8'h08
        |=> enable_mask[$past(cmd.arg_a[2:0])] == $past(cmd.arg_b))
        else $error("mask bit not written");
    mask_hold_a: assert property (!is_set |=> $stable(enable_mask))
        else $error("mask changed without a write");
    summary_and_a: assert property
        (event_summary == |(event_status & enable_mask))
        else $error("summary bit wrong");
    srq_gate_a: assert property (service_request ==
        (event_summary && $past(spoll_summary_enable)))
        else $error("service request wrong");
    err_word_a: assert property (cmd.valid &&
        cmd.code == ser_pkg::CMD_ERROR_QUERY |=> reply.value ==
        $past(error_status) && error_status == ($past(error_set) & 16'h0fff))
        else $error("error word read or clear wrong");
    err_bit_a: assert property (cmd.valid &&
        cmd.code == ser_pkg::CMD_ERROR_BIT_QUERY && cmd.arg_a < 8'h10
        |=> reply.value == $past(err_sel))
        else $error("error bit answer wrong");
    selftest_set_a: assert property (error_set[0] |=> error_status[0])
        else $error("selftest bit not set");
    en_query_a: assert property (cmd.valid &&
        cmd.code == ser_pkg::CMD_ENABLE_QUERY
        |=> reply.value == {8'h00, $past(enable_mask)})
        else $error("mask query wrong");
    cover property (is_set ##1 reply.valid == 1'b0);
    cover property (cmd.valid && cmd.code == ser_pkg::CMD_ERROR_QUERY);
    cover property ($rose(service_request));
endmodule
`default_nettype wire

// ---- tb/test_ser_status_event.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_ser_status_event;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clear_status = 1'b0;
    logic power_on_clear = 1'b0;
    logic power_up = 1'b0;
    logic [7:0] event_set = 8'h00;
    logic [15:0] error_set = 16'h0000;
    logic spoll_summary_enable = 1'b0;
    ser_pkg::ser_cmd_t cmd;
    ser_pkg::ser_reply_t reply;
    logic [7:0] enable_mask;
    logic [7:0] event_status;
    logic [15:0] error_status;
    logic event_summary;
    logic service_request;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'hf007;
    logic [7:0] mask;
    logic [15:0] word;
    int failures = 0;
    int checked = 0;
    always #2.5 sys_clk = ~sys_clk;
    ser_host host (.sys_clk(sys_clk), .cmd(cmd));
    ser_status_event uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd),
        .clear_status(clear_status), .power_on_clear(power_on_clear),
        .power_up(power_up), .event_set(event_set), .error_set(error_set),
        .spoll_summary_enable(spoll_summary_enable), .reply(reply),
        .enable_mask(enable_mask), .event_status(event_status),
        .error_status(error_status), .event_summary(event_summary),
        .service_request(service_request));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Notes the expected answer, then has the host send the query.
    task automatic ask(input logic [2:0] c, input logic [7:0] a,
        input logic [15:0] exp);
        exp_q.push_back(exp);
        host.send(c, a, 1'b0);
    endtask
    // One-cycle pulses on the event and error sources.
    task automatic strike(input logic [7:0] ev, input logic [15:0] er);
        @(negedge sys_clk);
        event_set = ev;
        error_set = er;
        @(negedge sys_clk);
        event_set = 8'h00;
        error_set = 16'h0000;
    endtask
    // Every reply is matched to the oldest noted answer.
    always @(negedge sys_clk)
        if (reply.valid === 1'b1)
        begin
            check(16'(exp_q.size() != 0), 16'h0001);
            if (exp_q.size() != 0)
                check(reply.value, exp_q.pop_front());
        end
    initial
    begin
        #200000 failures++;
        final_report();
    end
    initial
    begin
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b0;
        check(error_status | {enable_mask, event_status}, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            mask = seed[7:0];
            host.send(ser_pkg::CMD_ENABLE_SET, mask, 1'b0);
            ask(ser_pkg::CMD_ENABLE_QUERY, 8'h00, {8'h00, mask});
        end
        for (int i = 0; i < 9; i++)
        begin
            seed = xs(seed);
            host.send(ser_pkg::CMD_ENABLE_BIT_SET, 8'(i), seed[0]);
            if (i < 8)
                mask[i] = seed[0];
            ask(ser_pkg::CMD_ENABLE_BIT_QUERY, 8'(i),
                16'(i < 8 && seed[0]));
        end
        ask(ser_pkg::CMD_ENABLE_QUERY, 8'h00, {8'h00, mask});
        host.send(ser_pkg::CMD_ENABLE_SET, 8'h10, 1'b0);
        host.send(ser_pkg::CMD_NONE, 8'h55, 1'b1);
        check(16'(enable_mask), 16'h0010);
        @(negedge sys_clk);
        spoll_summary_enable = 1'b1;
        strike(8'h21, 16'h0000);
        check(16'({event_status, event_summary}), 16'h0042);
        strike(8'hff, 16'h0000);
        check(16'({event_status, event_summary, service_request}),
            16'h02c7);
        host.send(ser_pkg::CMD_ENABLE_SET, 8'h00, 1'b0);
        @(negedge sys_clk);
        check(16'({event_status, event_summary}), 16'h0162);
        ask(ser_pkg::CMD_STATUS_QUERY, 8'h00, 16'h00b1);
        @(negedge sys_clk);
        check(16'(event_status), 16'h0000);
        for (int k = 0; k < 3; k++)
        begin
            strike(8'h80, 16'h0000);
            {power_on_clear, power_up, clear_status} = k == 0 ? 3'h2 :
                (k == 1 ? 3'h6 : 3'h1);
            @(negedge sys_clk);
            {power_on_clear, power_up, clear_status} = 3'h0;
            check(16'(event_status), k == 0 ? 16'h0080 : 16'h0000);
        end
        seed = xs(seed);
        strike(8'h00, seed[15:0] | 16'h0001);
        word = (seed[15:0] | 16'h0001) & 16'h0fff;
        check(error_status, word);
        ask(ser_pkg::CMD_ERROR_BIT_QUERY, 8'h00, 16'h0001);
        ask(ser_pkg::CMD_ERROR_BIT_QUERY, 8'h11, 16'h0000);
        word[0] = 1'b0;
        @(negedge sys_clk);
        check(error_status, word);
        ask(ser_pkg::CMD_ERROR_QUERY, 8'h00, word);
        @(negedge sys_clk);
        check(error_status, 16'h0000);
        repeat (3) @(negedge sys_clk);
        check(16'(exp_q.size()), 16'h0000);
        final_report();
    end
endmodule
bind ser_status_event ser_status_event_props chk (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .cmd(cmd), .error_set(error_set),
    .spoll_summary_enable(spoll_summary_enable), .reply(reply),
    .enable_mask(enable_mask), .event_status(event_status),
    .error_status(error_status), .event_summary(event_summary),
    .service_request(service_request));
`default_nettype wire
